//--- io_port_pkg.sv
package io_port_pkg;

  localparam int unsigned NUM_PINS = 8;
  localparam int unsigned NUM_OE_LINES = 16;
  localparam int unsigned OE_SEL_W = 4;

  // Drive-mode codes
  typedef enum logic [2:0] {
    DM_HIZ_ANALOG  = 3'h0,
    DM_HIZ_DIGITAL = 3'h1,
    DM_RES_PULLUP  = 3'h2,
    DM_RES_PULLDN  = 3'h3,
    DM_OD_LOW      = 3'h4,
    DM_OD_HIGH     = 3'h5,
    DM_STRONG      = 3'h6,
    DM_RES_UPDN    = 3'h7
  } drive_mode_t;

  // Interrupt type per pin
  typedef enum logic [1:0] {
    IRQ_NONE    = 2'h0,
    IRQ_RISING  = 2'h1,
    IRQ_FALLING = 2'h2,
    IRQ_BOTH    = 2'h3
  } irq_type_t;

  // Special pin input threshold choice, one per pair
  typedef enum logic [1:0] {
    THR_HALF_VDDIO  = 2'h0,
    THR_0P4_VDDIO   = 2'h1,
    THR_HALF_VREF   = 2'h2,
    THR_FULL_VREF   = 2'h3
  } thresh_sel_t;

  // Pin-form register: eight most-used configuration bits of one pin
  typedef struct packed {
    logic       in_disable;
    logic       bidir_en;
    logic       slow_slew;
    logic [2:0] drive_mode;
    logic       data_out;
    logic       bypass;
  } pin_cfg_t;

  // Analog-side controls for one pad
  typedef struct packed {
    logic drive_hi;
    logic drive_lo;
    logic res_hi;
    logic res_lo;
    logic slow_slew;
    logic in_en;
  } pad_ctrl_t;

  // Port-form write selects
  typedef enum logic [2:0] {
    PW_DATA     = 3'h0,
    PW_DM0      = 3'h1,
    PW_DM1      = 3'h2,
    PW_DM2      = 3'h3,
    PW_SLEW     = 3'h4,
    PW_INDIS    = 3'h5,
    PW_BIDIR    = 3'h6,
    PW_BYPASS   = 3'h7
  } port_wsel_t;

  localparam logic [7:0] PORT_DATA_RST = 8'h00;
  localparam logic [2:0] RSTCFG_NONE = 3'h0;

endpackage

//--- pin_edge_detect.sv
`timescale 1ns/1ps
`default_nettype none
module pin_edge_detect
  import io_port_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic level_i,
  input wire irq_type_t type_i,
  output logic event_o
);
  logic prev_r;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= level_i;
    end
  end

  // Edges only; no level detection exists anywhere in the port
  always_comb begin
    case (type_i)
      IRQ_RISING: event_o = level_i & ~prev_r;
      IRQ_FALLING: event_o = ~level_i & prev_r;
      IRQ_BOTH: event_o = level_i ^ prev_r;
      default: event_o = 1'b0;
    endcase
  end
endmodule // pin_edge_detect
`default_nettype wire

//--- pad_drive_decode.sv
`timescale 1ns/1ps
`default_nettype none
module pad_drive_decode
  import io_port_pkg::*;
(
  input wire logic [2:0] mode_i,
  input wire logic data_i,
  input wire logic slow_i,
  input wire logic in_dis_i,
  input wire logic regulated_i,
  output pad_ctrl_t ctrl_o
);
  logic [2:0] eff_mode;

  always_comb begin
    eff_mode = mode_i;
    // Resistive modes unavailable under regulated output
    if (regulated_i && (mode_i == DM_RES_PULLUP || mode_i == DM_RES_PULLDN ||
        mode_i == DM_RES_UPDN)) begin
      eff_mode = DM_HIZ_DIGITAL;
    end
    ctrl_o = '0;
    case (drive_mode_t'(eff_mode))
      DM_HIZ_ANALOG: ctrl_o.in_en = 1'b0;
      DM_HIZ_DIGITAL: ctrl_o.in_en = 1'b1;
      DM_RES_PULLUP: begin
        ctrl_o.res_hi = data_i;
        ctrl_o.drive_lo = ~data_i;
        ctrl_o.in_en = 1'b1;
      end
      DM_RES_PULLDN: begin
        ctrl_o.drive_hi = data_i;
        ctrl_o.res_lo = ~data_i;
        ctrl_o.in_en = 1'b1;
      end
      DM_OD_LOW: begin
        ctrl_o.drive_lo = ~data_i;
        ctrl_o.in_en = 1'b1;
      end
      DM_OD_HIGH: begin
        ctrl_o.drive_hi = data_i;
        ctrl_o.in_en = 1'b1;
      end
      DM_STRONG: begin
        ctrl_o.drive_hi = data_i;
        ctrl_o.drive_lo = ~data_i;
        ctrl_o.in_en = 1'b1;
      end
      DM_RES_UPDN: begin
        ctrl_o.res_hi = data_i;
        ctrl_o.res_lo = ~data_i;
        ctrl_o.in_en = 1'b1;
      end
      default: ctrl_o = '0;
    endcase
    // Slew only matters for strong and open-drain
    ctrl_o.slow_slew = slow_i & (eff_mode[2] & ~(eff_mode[1] & eff_mode[0]));
    if (in_dis_i) begin
      ctrl_o.in_en = 1'b0;
    end
  end
endmodule // pad_drive_decode
`default_nettype wire

//--- io_port_pin_control.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Each pin holds a 3-bit drive-mode code selecting one of eight modes.
// - Pin levels are read from a separate register from output data.
// - Combined resistive mode pulls up on data high, down on data low.
// - Regulated special pins lose the three resistive drive modes.
// - Port-form writes reconfigure many pins at once, one bit per pin.
// - Pin-form write of eight bits hits the same storage as port form.
// - Bidirectional pin is digital high-Z unless its routed enable is active.
// - Sixteen output-enable lines, each routable to any pins.
// - Slew bit per pin, effective only in strong and open-drain modes.
// - All eight pins feed one port interrupt unit with one request.
// - Per-pin interrupt type: none, rising, falling or both.
// - Detected edge sets the pin status bit and raises the request.
// - Edge detection and request keep working in every sleep mode.
// - No level-sensitive detection in the interrupt unit.
// - Port-level choice of CMOS or LVTTL input thresholds.
// - Per-pin input disable forces the digital input inactive.
// - Per special pin choice of supply-level or regulated high output.
// - Special pins pair up sharing one of four input thresholds.
// - During reset every pin sits in high-impedance analog mode.
// - Stored reset configuration loads into port reset registers at release.
// - Pins keep their drive state through every low-power mode.
module io_port_pin_control
  import io_port_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Port-form write
  input wire logic port_wr_i,
  input wire port_wsel_t port_wsel_i,
  input wire logic [7:0] port_wdata_i,
  // Pin-form write
  input wire logic pin_wr_i,
  input wire logic [2:0] pin_idx_i,
  input wire pin_cfg_t pin_wdata_i,
  // Interrupt and misc configuration
  input wire logic irq_type_wr_i,
  input wire logic [15:0] irq_type_i,
  input wire logic oe_sel_wr_i,
  input wire logic [31:0] oe_sel_i,
  input wire logic lvttl_i,
  input wire logic [7:0] regulated_i,
  input wire logic [7:0] thresh_i,
  input wire logic sleep_i,
  // Stored reset configuration
  input wire logic [2:0] nv_rst_mode_i,
  // Status access
  input wire logic stat_rd_i,
  output logic [7:0] stat_o,
  output logic [7:0] pin_level_o,
  output logic irq_o,
  // Fabric and pins
  input wire logic [15:0] aux_oe_i,
  input wire logic [7:0] fabric_out_i,
  input wire logic [7:0] pad_in_i,
  output logic [7:0] fabric_in_o,
  output pad_ctrl_t [7:0] pad_ctrl_o,
  output logic lvttl_o,
  output logic [7:0] regulated_o,
  output logic [7:0] thresh_o
);
  logic [7:0] data_r;
  logic [7:0] dm0_r;
  logic [7:0] dm1_r;
  logic [7:0] dm2_r;
  logic [7:0] slew_r;
  logic [7:0] indis_r;
  logic [7:0] bidir_r;
  logic [7:0] bypass_r;
  logic [15:0] itype_r;
  logic [31:0] oesel_r;
  logic rst_load_r;
  logic [7:0] stat_r;
  logic [7:0] stat_nxt;
  logic [7:0] level_r;
  logic [7:0] event_w;
  logic [7:0] inen_w;
  pad_ctrl_t [7:0] ctrl_w;

  // Configuration storage, shared by both views
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      data_r <= PORT_DATA_RST;
      dm0_r <= 8'h00;
      dm1_r <= 8'h00;
      dm2_r <= 8'h00;
      slew_r <= 8'h00;
      indis_r <= 8'h00;
      bidir_r <= 8'h00;
      bypass_r <= 8'h00;
    end else if (rst_load_r) begin
      // Stored reset mode applied once after release
      // Taken straight from its pins: a captured copy would land one edge late
      dm0_r <= {8{nv_rst_mode_i[0]}};
      dm1_r <= {8{nv_rst_mode_i[1]}};
      dm2_r <= {8{nv_rst_mode_i[2]}};
      data_r <= {8{nv_rst_mode_i == DM_RES_PULLUP}};
    end else if (port_wr_i) begin
      case (port_wsel_i)
        PW_DATA: data_r <= port_wdata_i;
        PW_DM0: dm0_r <= port_wdata_i;
        PW_DM1: dm1_r <= port_wdata_i;
        PW_DM2: dm2_r <= port_wdata_i;
        PW_SLEW: slew_r <= port_wdata_i;
        PW_INDIS: indis_r <= port_wdata_i;
        PW_BIDIR: bidir_r <= port_wdata_i;
        PW_BYPASS: bypass_r <= port_wdata_i;
        default: data_r <= data_r;
      endcase
    end else if (pin_wr_i) begin
      data_r[pin_idx_i] <= pin_wdata_i.data_out;
      dm0_r[pin_idx_i] <= pin_wdata_i.drive_mode[0];
      dm1_r[pin_idx_i] <= pin_wdata_i.drive_mode[1];
      dm2_r[pin_idx_i] <= pin_wdata_i.drive_mode[2];
      slew_r[pin_idx_i] <= pin_wdata_i.slow_slew;
      indis_r[pin_idx_i] <= pin_wdata_i.in_disable;
      bidir_r[pin_idx_i] <= pin_wdata_i.bidir_en;
      bypass_r[pin_idx_i] <= pin_wdata_i.bypass;
    end
  end

  // Load flag: high through reset and for the first edge after release
  // Port-form and pin-form writes in that cycle are dropped so the stored mode always lands
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rst_load_r <= 1'b1;
    end else begin
      rst_load_r <= 1'b0;
    end
  end

  // Interrupt type and enable routing
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      itype_r <= 16'h0000;
      oesel_r <= 32'h00000000;
    end else begin
      if (irq_type_wr_i) begin
        itype_r <= irq_type_i;
      end
      if (oe_sel_wr_i) begin
        oesel_r <= oe_sel_i;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pin
      logic out_bit;
      logic [2:0] mode;
      logic oe_act;
      assign out_bit = bypass_r[g] ? fabric_out_i[g] : data_r[g];
      assign oe_act = aux_oe_i[oesel_r[g*OE_SEL_W +: OE_SEL_W]];
      // Bidirectional: digital high-Z while routed enable is low
      assign mode = (bidir_r[g] && !oe_act) ? DM_HIZ_DIGITAL :
                    {dm2_r[g], dm1_r[g], dm0_r[g]};
      pad_drive_decode u_dec (
        .mode_i(mode),
        .data_i(out_bit),
        .slow_i(slew_r[g]),
        .in_dis_i(indis_r[g]),
        .regulated_i(regulated_o[g]),
        .ctrl_o(ctrl_w[g])
      );
      assign inen_w[g] = ctrl_w[g].in_en;
      // Edge logic runs on the system clock in sleep too
      pin_edge_detect u_edge (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .level_i(level_r[g]),
        .type_i(irq_type_t'(itype_r[2*g +: 2])),
        .event_o(event_w[g])
      );
      // Per-pin checks on the applied mode, the decoded pad controls and edge events
      a_pin_mode: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        !bidir_r[g] || oe_act |-> mode == {dm2_r[g], dm1_r[g], dm0_r[g]})
        else $error("drive mode bits not applied");
      a_bidir_hiz: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        bidir_r[g] && !oe_act |->
        {ctrl_w[g].drive_hi, ctrl_w[g].drive_lo, ctrl_w[g].res_hi, ctrl_w[g].res_lo} == 4'h0)
        else $error("bidir pin driven without enable");
      a_reg_no_res: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        regulated_o[g] |-> !ctrl_w[g].res_hi && !ctrl_w[g].res_lo)
        else $error("resistor on regulated pin");
      a_slew_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        ctrl_w[g].slow_slew |-> mode inside {DM_OD_LOW, DM_OD_HIGH, DM_STRONG})
        else $error("slow slew outside strong and open drain");
      a_in_disable: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        indis_r[g] |-> !ctrl_w[g].in_en)
        else $error("disabled input still enabled");
      a_no_type_event: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        irq_type_t'(itype_r[2*g +: 2]) == IRQ_NONE |-> !event_w[g])
        else $error("event on pin without interrupt type");
    end
  endgenerate

  // Pin level register, separate from output data
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      level_r <= 8'h00;
      fabric_in_o <= 8'h00;
    end else begin
      level_r <= pad_in_i & inen_w;
      fabric_in_o <= pad_in_i & inen_w;
    end
  end

  // Set wins over read-clear
  always_comb begin
    stat_nxt = stat_r;
    if (stat_rd_i) begin
      stat_nxt = 8'h00;
    end
    stat_nxt = stat_nxt | event_w;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      stat_r <= 8'h00;
      stat_o <= 8'h00;
      irq_o <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      stat_o <= stat_nxt;
      irq_o <= |stat_nxt;
    end
  end

  // Pad outputs; held unchanged by sleep, since nothing gates them
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || rst_load_r) begin
      pad_ctrl_o <= '0;
      lvttl_o <= 1'b0;
      regulated_o <= 8'h00;
      thresh_o <= 8'h00;
      pin_level_o <= 8'h00;
    end else begin
      pad_ctrl_o <= ctrl_w;
      lvttl_o <= lvttl_i;
      regulated_o <= regulated_i;
      thresh_o <= thresh_i;
      pin_level_o <= level_r;
    end
  end

  logic unused_sleep;
  assign unused_sleep = sleep_i;

  // Storage, status and pad checks
  a_reset_hiz: assert property (@(posedge sys_clk_i)
    !rst_n_i |=> pad_ctrl_o == '0)
    else $error("pad not hiz after reset");
  a_reset_load: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    rst_load_r |=> {dm2_r[0], dm1_r[0], dm0_r[0]} == $past(nv_rst_mode_i))
    else $error("stored reset mode not loaded");
  a_status_set: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    |event_w |=> (stat_r & $past(event_w)) == $past(event_w))
    else $error("event lost");
  a_irq_follows: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    irq_o == |stat_r)
    else $error("irq mismatch");
  a_read_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    stat_rd_i && !(|event_w) |=> stat_r == 8'h00)
    else $error("no clear");
  a_data_isolated: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !port_wr_i && !pin_wr_i && !rst_load_r |=> $stable(data_r))
    else $error("data changed");
  a_pin_form: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    pin_wr_i && !port_wr_i && !rst_load_r |=>
    dm2_r[$past(pin_idx_i)] == $past(pin_wdata_i.drive_mode[2]))
    else $error("pin form lost");
  a_port_form: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    port_wr_i && port_wsel_i == PW_SLEW && !rst_load_r |=> slew_r == $past(port_wdata_i))
    else $error("port form lost");
  a_level_path: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ##1 level_r == ($past(pad_in_i) & $past(inen_w)))
    else $error("level path");
  a_no_level_irq: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $stable(level_r) |-> event_w == 8'h00)
    else $error("level irq");
  a_sleep_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    sleep_i && !rst_load_r |=> pad_ctrl_o == $past(ctrl_w))
    else $error("pads moved in sleep");
  a_config_pass: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !rst_load_r |=> lvttl_o == $past(lvttl_i) && thresh_o == $past(thresh_i))
    else $error("port input setting lost");
  a_regulated_pass: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !rst_load_r |=> regulated_o == $past(regulated_i))
    else $error("regulated select lost");

  // Main scenarios
  c_reset_load: cover property (@(posedge sys_clk_i) $fell(rst_load_r));
  c_irq: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) $rose(irq_o));
  c_clear: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    stat_rd_i && irq_o ##2 !irq_o);
  c_pinwr: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) pin_wr_i);
  c_sleep_event: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    sleep_i && |event_w);
endmodule // io_port_pin_control
`default_nettype wire

//--- pad_env_model.sv
`timescale 1ns/1ps
`default_nettype none
module pad_env_model
  import io_port_pkg::*;
(
  // Clock
  input wire logic sys_clk_i,
  // Pads and outside sources
  input wire pad_ctrl_t [7:0] pad_ctrl_i,
  input wire logic [7:0] ext_en_i,
  input wire logic [7:0] ext_val_i,
  output logic [7:0] pad_in_o
);
  // Undriven pads wander, so a stale level never passes for a driven one
  logic [7:0] float_r = 8'h00;
  always_ff @(posedge sys_clk_i) begin
    float_r <= ~float_r;
  end
  // Strong drive beats the outside source, which beats a resistor
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_ctrl_i[i].drive_hi) pad_in_o[i] = 1'b1;
      else if (pad_ctrl_i[i].drive_lo) pad_in_o[i] = 1'b0;
      else if (ext_en_i[i]) pad_in_o[i] = ext_val_i[i];
      else if (pad_ctrl_i[i].res_hi) pad_in_o[i] = 1'b1;
      else if (pad_ctrl_i[i].res_lo) pad_in_o[i] = 1'b0;
      else pad_in_o[i] = float_r[i];
    end
  end
endmodule // pad_env_model
`default_nettype wire

//--- io_port_pin_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module io_port_pin_control_tb_top;
  import io_port_pkg::*;
  logic sys_clk_i, rst_n_i, port_wr_i, pin_wr_i, irq_type_wr_i, oe_sel_wr_i;
  logic lvttl_i, sleep_i, stat_rd_i, irq_o, lvttl_o;
  port_wsel_t port_wsel_i;
  logic [7:0] port_wdata_i, regulated_i, thresh_i, stat_o, pin_level_o, fabric_in_o;
  logic [7:0] pad_in_i, regulated_o, thresh_o, ext_en, ext_val;
  logic [2:0] pin_idx_i, nv_rst_mode_i;
  pin_cfg_t pin_wdata_i;
  logic [15:0] irq_type_i, aux_oe_i;
  logic [31:0] oe_sel_i;
  pad_ctrl_t [7:0] pad_ctrl_o;
  int fails, num_checks;

  io_port_pin_control io_port_pin_control_i (
    .sys_clk_i, .rst_n_i, .port_wr_i, .port_wsel_i, .port_wdata_i, .pin_wr_i,
    .pin_idx_i, .pin_wdata_i, .irq_type_wr_i, .irq_type_i, .oe_sel_wr_i, .oe_sel_i,
    .lvttl_i, .regulated_i, .thresh_i, .sleep_i, .nv_rst_mode_i, .stat_rd_i, .stat_o,
    .pin_level_o, .irq_o, .aux_oe_i, .fabric_out_i(8'h00), .pad_in_i, .fabric_in_o,
    .pad_ctrl_o, .lvttl_o, .regulated_o, .thresh_o
  );
  pad_env_model pad_env_model_i (
    .sys_clk_i, .pad_ctrl_i(pad_ctrl_o), .ext_en_i(ext_en), .ext_val_i(ext_val),
    .pad_in_o(pad_in_i)
  );

  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic pw(input port_wsel_t s, input logic [7:0] d);
    @(negedge sys_clk_i);
    port_wr_i = 1'b1;
    port_wsel_i = s;
    port_wdata_i = d;
  endtask
  // Drop every write strobe, then let storage reach the pads
  task automatic idle();
    @(negedge sys_clk_i);
    port_wr_i = 1'b0;
    pin_wr_i = 1'b0;
    irq_type_wr_i = 1'b0;
    oe_sel_wr_i = 1'b0;
    tick(2);
  endtask
  task automatic rd();
    @(negedge sys_clk_i);
    stat_rd_i = 1'b1;
    @(negedge sys_clk_i);
    stat_rd_i = 1'b0;
  endtask
  // Pad fields {drive_hi, drive_lo, res_hi, res_lo} for a mode and data bit
  function automatic logic [3:0] exp_drv(input logic [2:0] m, input logic d);
    case (m)
      3'h2: return d ? 4'b0010 : 4'b0100;
      3'h3: return d ? 4'b1000 : 4'b0001;
      3'h4: return d ? 4'b0000 : 4'b0100;
      3'h5: return d ? 4'b1000 : 4'b0000;
      3'h6: return d ? 4'b1000 : 4'b0100;
      3'h7: return d ? 4'b0010 : 4'b0001;
      default: return 4'b0000;
    endcase
  endfunction
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #100000;
    fails++;
    end_sim();
  end

  initial begin
    {rst_n_i, port_wr_i, pin_wr_i, irq_type_wr_i, oe_sel_wr_i, lvttl_i, sleep_i} = '0;
    {stat_rd_i, port_wdata_i, regulated_i, thresh_i, ext_en, ext_val, pin_idx_i} = '0;
    {pin_wdata_i, irq_type_i, aux_oe_i, oe_sel_i} = '0;
    port_wsel_i = PW_DATA;
    nv_rst_mode_i = DM_RES_PULLUP;
    tick(8);
    for (int i = 0; i < 8; i++) check("pad in reset", 8'(pad_ctrl_o[i]), 8'h00);
    rst_n_i = 1'b1;
    tick(4);
    for (int i = 0; i < 8; i++) check("reset load", 8'(pad_ctrl_o[i][5:2]), 8'h02);
    $display("test reset done");
    regulated_i = 8'h10;
    pw(PW_SLEW, 8'hff);
    for (int m = 0; m < 8; m++) begin
      for (int d = 0; d < 2; d++) begin
        pw(PW_DM0, {8{m[0]}});
        pw(PW_DM1, {8{m[1]}});
        pw(PW_DM2, {8{m[2]}});
        pw(PW_DATA, {8{d[0]}});
        idle();
        check("drive pin5", 8'(pad_ctrl_o[5][5:2]), 8'(exp_drv(3'(m), d[0])));
        check("drive pin4", 8'(pad_ctrl_o[4][5:2]),
              (m == 2 || m == 3 || m == 7) ? 8'h00 : 8'(exp_drv(3'(m), d[0])));
        check("slew pin5", 8'(pad_ctrl_o[5].slow_slew), 8'(m inside {4, 5, 6}));
      end
    end
    $display("test modes done");
    @(negedge sys_clk_i);
    oe_sel_wr_i = 1'b1;
    oe_sel_i = 32'h0000_0050;
    pin_wr_i = 1'b1;
    pin_idx_i = 3'h1;
    pin_wdata_i = '{in_disable: 1'b0, bidir_en: 1'b1, slow_slew: 1'b0,
                    drive_mode: DM_STRONG, data_out: 1'b1, bypass: 1'b0};
    idle();
    check("bidir off", 8'(pad_ctrl_o[1][5:2]), 8'h00);
    aux_oe_i = 16'h0020;
    tick(3);
    check("bidir on", 8'(pad_ctrl_o[1][5:2]), 8'h08);
    pw(PW_DATA, 8'h00);
    idle();
    check("pin form shared", 8'(pad_ctrl_o[1][5:2]), 8'h04);
    $display("test bidir done");
    pw(PW_DM0, 8'hfe);
    pw(PW_DM1, 8'h00);
    pw(PW_DM2, 8'h01);
    pw(PW_BIDIR, 8'h00);
    pw(PW_DATA, 8'h01);
    ext_en = 8'hff;
    ext_val = 8'ha5;
    idle();
    tick(1);
    check("pin level", pin_level_o, 8'ha5);
    check("open drain released", 8'(pad_ctrl_o[0][5:2]), 8'h00);
    pw(PW_INDIS, 8'h0f);
    idle();
    tick(1);
    check("level disabled", pin_level_o, 8'ha0);
    check("fabric disabled", fabric_in_o & 8'h0f, 8'h00);
    check("input off pin0", 8'(pad_ctrl_o[0].in_en), 8'h00);
    $display("test input done");
    sleep_i = 1'b1;
    pw(PW_INDIS, 8'h00);
    ext_val = 8'h00;
    irq_type_wr_i = 1'b1;
    irq_type_i = 16'h0039;
    idle();
    tick(2);
    rd();
    check("status cleared", stat_o, 8'h00);
    check("request low", 8'(irq_o), 8'h00);
    ext_val = 8'h0f;
    tick(3);
    check("rise status", stat_o, 8'h05);
    check("request high", 8'(irq_o), 8'h01);
    rd();
    check("status read", stat_o, 8'h00);
    check("request drop", 8'(irq_o), 8'h00);
    ext_val = 8'h00;
    tick(3);
    check("fall status", stat_o, 8'h06);
    rd();
    tick(4);
    check("no level event", stat_o, 8'h00);
    $display("test interrupt done");
    lvttl_i = 1'b1;
    thresh_i = 8'h9c;
    tick(2);
    check("threshold kind", 8'(lvttl_o), 8'h01);
    check("regulated", regulated_o, 8'h10);
    check("pair threshold", thresh_o, 8'h9c);
    $display("test misc done");
    end_sim();
  end
endmodule // io_port_pin_control_tb_top
`default_nettype wire
